/* File: verilog/alu_move_map.vh */
// constants for the move / add / compare execution datapath
// assumes: included by the datapath module, its checker and the bench
`ifndef ALU_MOVE_MAP_VH
`define ALU_MOVE_MAP_VH
// operation codes presented by the sequencer
`define OP_NOP        5'h00
`define OP_WMOV_IMM   5'h01
`define OP_WMOV_IO    5'h02
`define OP_LMOV_IMM   5'h03
`define OP_BADDC_DEC  5'h04
`define OP_BSUBC_DEC  5'h05
`define OP_BADD_MEM   5'h06
`define OP_BSUB_MEM   5'h07
`define OP_WADD_ACC   5'h08
`define OP_WADDC_REG  5'h09
`define OP_LADD_IMM   5'h0a
`define OP_LADD_REG   5'h0b
`define OP_INC        5'h0c
`define OP_DEC        5'h0d
`define OP_CMP        5'h0e
`define OP_WXCH       5'h0f
`define OP_WST_IND    5'h10
// operand widths
`define W_BYTE        2'h0
`define W_WORD        2'h1
`define W_LONG        2'h2
// byte lengths
`define LEN_1         3'h1
`define LEN_2         3'h2
`define LEN_3         3'h3
`define LEN_4         3'h4
`define LEN_5         3'h5
// base cycle counts
`define CYC_1         4'h1
`define CYC_2         4'h2
`define CYC_3         4'h3
`define CYC_4         4'h4
`define CYC_5         4'h5
// flag bit positions in the flag vector {n,z,v,c}
`define FLG_N         3
`define FLG_Z         2
`define FLG_V         1
`define FLG_C         0
`endif

/* File: verilog/alu_move_dp.v */
// execution datapath for word/long moves, add/subtract, inc/dec, compare
// assumes: sequencer holds operands stable while busy; memory unit supplies
// addressing cost and access correction for memory operands
`timescale 1ns/100ps
`include "alu_move_map.vh"

// Functional notes
// - word immediate load: 3 bytes, 2 cycles, old low half pushed high, flags n z
// - word immediate store to io: 4 bytes, 3 cycles plus correction, no flags
// - long immediate load: 5 bytes, 3 cycles, flags from 32-bit value, no push
// - decimal add high byte plus low byte plus carry; 1 byte 3 cycles; clear 15:8
// - decimal subtract low byte and carry from high byte; 1 byte 3 cycles; clear 15:8
// - byte add/sub to memory is read-modify-write, 3 plus address plus twice correction
// - word add of high and low halves into low half, 1 byte 2 cycles
// - word add with carry of register operand into low half, 2 bytes 2 cycles
// - inc/dec is read-modify-write, n z v updated, carry kept; long register 4 cycles
// - compare subtracts second from first, stores nothing, sets n z v c
// - word exchange register with operand, 2 bytes 4 cycles, flags untouched
// - where marked, old low half is copied to high half before new low write
// - where marked, accumulator bits 15 to 8 are forced to zero
module alu_move_dp
(
  // clock and reset
  input  wire        clk_in,
  input  wire        sys_rst_in,
  // instruction request from sequencer
  input  wire        start_in,
  input  wire [4:0]  op_in,
  input  wire [1:0]  width_in,
  input  wire        mem_op_in,
  input  wire [3:0]  addr_cost_in,
  input  wire [3:0]  acc_corr_in,
  input  wire [31:0] imm_in,
  input  wire [31:0] operand_in,
  input  wire [15:0] general_word_reg_in,
  // result to sequencer and memory unit
  output reg         busy_out,
  output reg         done_out,
  output reg  [2:0]  inst_len_out,
  output reg  [5:0]  cycles_out,
  output reg  [15:0] acc_high_half_out,
  output reg  [15:0] acc_low_half_out,
  output reg  [3:0]  flags_out,
  output reg  [31:0] result_out,
  output reg         result_we_out,
  output reg  [15:0] general_word_reg_out,
  output reg         general_word_reg_we_out,
  output reg  [15:0] store_addr_out
);

  // ==========================================================
  // state
  // ==========================================================
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN  = 1'b1;

  reg        state_ff;
  reg [5:0]  cnt_ff;
  reg [15:0] nxt_ah;
  reg [15:0] nxt_al;
  reg [3:0]  nxt_flg;
  reg [31:0] nxt_res;
  reg        nxt_res_we;
  reg [15:0] nxt_gw;
  reg        nxt_gw_we;
  reg [15:0] nxt_sa;
  reg [2:0]  nxt_len;
  reg [3:0]  nxt_base;
  reg        nxt_rmw;
  reg [32:0] sum;
  reg [31:0] a_val;
  reg [31:0] b_val;
  reg [8:0]  dsum;
  reg [5:0]  total;
  reg [3:0]  aflg;

  // ==========================================================
  // helpers
  // ==========================================================
  // sign bit of a value at the given width
  function msb_of;
    input [31:0] v;
    input [1:0]  w;
    begin
      msb_of = (w == `W_BYTE) ? v[7] : (w == `W_WORD) ? v[15] : v[31];
    end
  endfunction

  // mask down to operand width so zero tests see only live bits
  function [31:0] trim;
    input [31:0] v;
    input [1:0]  w;
    begin
      trim = (w == `W_BYTE) ? {24'h0000_00, v[7:0]} :
             (w == `W_WORD) ? {16'h0000, v[15:0]} : v;
    end
  endfunction

  // carry out of the operand width from a 33-bit sum
  function carry_of;
    input [32:0] s;
    input [1:0]  w;
    begin
      carry_of = (w == `W_BYTE) ? s[8] : (w == `W_WORD) ? s[16] : s[32];
    end
  endfunction

  // n z v c from a binary add (sub=0) or subtract (sub=1); the subtract is
  // done directly, so the bit above the width is already the borrow
  function [3:0] arith_flags;
    input [31:0] a;
    input [31:0] b;
    input [32:0] s;
    input [1:0]  w;
    input        sub;
    reg          sa;
    reg          sb;
    reg          sr;
    begin
      sa = msb_of(a, w);
      sb = msb_of(b, w) ^ sub;
      sr = msb_of(s[31:0], w);
      arith_flags = {sr, (trim(s[31:0], w) == 32'h0000_0000),
                     (sa == sb) && (sr != sa), carry_of(s, w)};
    end
  endfunction

  // ==========================================================
  // decode and compute
  // ==========================================================
  // one combinational pass: the result is latched at start and shows at once,
  // all outputs on one edge, so the outside never sees a partial update
  always @*
  begin
    nxt_ah     = acc_high_half_out;
    nxt_al     = acc_low_half_out;
    nxt_flg    = flags_out;
    nxt_res    = 32'h0000_0000;
    nxt_res_we = 1'b0;
    nxt_gw     = general_word_reg_in;
    nxt_gw_we  = 1'b0;
    nxt_sa     = 16'h0000;
    nxt_len    = `LEN_2;
    nxt_base   = `CYC_2;
    nxt_rmw    = 1'b0;
    a_val      = 32'h0000_0000;
    b_val      = 32'h0000_0000;
    sum        = 33'h0_0000_0000;
    dsum       = 9'h000;
    aflg       = 4'h0;
    case (op_in)
      `OP_WMOV_IMM:
      begin
        nxt_ah   = acc_low_half_out;
        nxt_al   = imm_in[15:0];
        nxt_flg  = {imm_in[15], imm_in[15:0] == 16'h0000, flags_out[1:0]};
        nxt_len  = `LEN_3;
        nxt_base = `CYC_2;
      end
      `OP_WMOV_IO:
      begin
        nxt_res    = {16'h0000, imm_in[15:0]};
        nxt_res_we = 1'b1;
        nxt_len    = `LEN_4;
        nxt_base   = `CYC_3;
      end
      `OP_LMOV_IMM:
      begin
        nxt_ah   = imm_in[31:16];
        nxt_al   = imm_in[15:0];
        nxt_flg  = {imm_in[31], imm_in == 32'h0000_0000, flags_out[1:0]};
        nxt_len  = `LEN_5;
        nxt_base = `CYC_3;
      end
      `OP_BADDC_DEC:
      begin
        a_val = {24'h0000_00, acc_high_half_out[7:0]};
        b_val = {24'h0000_00, acc_low_half_out[7:0]};
        sum   = {1'b0, a_val} + {1'b0, b_val} + {32'h0000_0000, flags_out[`FLG_C]};
        dsum  = sum[8:0];
        // decimal adjust low then high digit
        if (dsum[3:0] > 4'h9 || ((a_val[3:0] + b_val[3:0] + {3'h0, flags_out[0]}) > 5'h09))
          dsum = dsum + 9'h006;
        if (dsum[8] || dsum[7:4] > 4'h9)
          dsum = dsum + 9'h060;
        nxt_al   = {8'h00, dsum[7:0]};
        nxt_flg  = {dsum[7], dsum[7:0] == 8'h00,
                    (a_val[7] == b_val[7]) && (dsum[7] != a_val[7]), dsum[8] | sum[8]};
        nxt_len  = `LEN_1;
        nxt_base = `CYC_3;
      end
      `OP_BSUBC_DEC:
      begin
        a_val = {24'h0000_00, acc_high_half_out[7:0]};
        b_val = {24'h0000_00, acc_low_half_out[7:0]};
        sum   = {1'b0, a_val} - {1'b0, b_val} - {32'h0000_0000, flags_out[`FLG_C]};
        dsum  = sum[8:0];
        // borrow out of a digit means subtract six from it
        if ({1'b0, a_val[3:0]} < ({1'b0, b_val[3:0]} + {4'h0, flags_out[0]}))
          dsum = dsum - 9'h006;
        if (sum[8])
          dsum = dsum - 9'h060;
        nxt_al   = {8'h00, dsum[7:0]};
        nxt_flg  = {dsum[7], dsum[7:0] == 8'h00,
                    (a_val[7] != b_val[7]) && (dsum[7] != a_val[7]), sum[8]};
        nxt_len  = `LEN_1;
        nxt_base = `CYC_3;
      end
      `OP_BADD_MEM, `OP_BSUB_MEM:
      begin
        a_val = {24'h0000_00, operand_in[7:0]};
        b_val = {24'h0000_00, acc_low_half_out[7:0]};
        if (op_in == `OP_BSUB_MEM)
          sum = {1'b0, a_val} - {1'b0, b_val};
        else
          sum = {1'b0, a_val} + {1'b0, b_val};
        nxt_res    = trim(sum[31:0], `W_BYTE);
        nxt_res_we = 1'b1;
        nxt_flg    = arith_flags(a_val, b_val, sum, `W_BYTE, op_in == `OP_BSUB_MEM);
        nxt_rmw    = 1'b1;
        nxt_base   = `CYC_3;
      end
      `OP_WADD_ACC:
      begin
        a_val    = {16'h0000, acc_high_half_out};
        b_val    = {16'h0000, acc_low_half_out};
        sum      = {1'b0, a_val} + {1'b0, b_val};
        nxt_al   = sum[15:0];
        nxt_flg  = arith_flags(a_val, b_val, sum, `W_WORD, 1'b0);
        nxt_len  = `LEN_1;
      end
      `OP_WADDC_REG:
      begin
        a_val    = {16'h0000, acc_low_half_out};
        b_val    = {16'h0000, operand_in[15:0]};
        sum      = {1'b0, a_val} + {1'b0, b_val} + {32'h0000_0000, flags_out[`FLG_C]};
        nxt_al   = sum[15:0];
        nxt_flg  = arith_flags(a_val, b_val, sum, `W_WORD, 1'b0);
      end
      `OP_LADD_IMM, `OP_LADD_REG:
      begin
        a_val    = {acc_high_half_out, acc_low_half_out};
        b_val    = (op_in == `OP_LADD_IMM) ? imm_in : operand_in;
        sum      = {1'b0, a_val} + {1'b0, b_val};
        nxt_ah   = sum[31:16];
        nxt_al   = sum[15:0];
        nxt_flg  = arith_flags(a_val, b_val, sum, `W_LONG, 1'b0);
        nxt_len  = (op_in == `OP_LADD_IMM) ? `LEN_5 : `LEN_2;
        nxt_base = (op_in == `OP_LADD_IMM) ? `CYC_4 : `CYC_5;
      end
      `OP_INC, `OP_DEC:
      begin
        a_val = trim(operand_in, width_in);
        b_val = 32'h0000_0001;
        if (op_in == `OP_DEC)
          sum = {1'b0, a_val} - {1'b0, b_val};
        else
          sum = {1'b0, a_val} + {1'b0, b_val};
        nxt_res    = trim(sum[31:0], width_in);
        nxt_res_we = 1'b1;
        aflg       = arith_flags(a_val, b_val, sum, width_in, op_in == `OP_DEC);
        nxt_flg    = {aflg[3:1], flags_out[`FLG_C]};
        nxt_rmw    = 1'b1;
        // memory forms pay one more base cycle than register forms
        if (width_in == `W_LONG)
          nxt_base = mem_op_in ? `CYC_5 : `CYC_4;
        else
          nxt_base = mem_op_in ? `CYC_3 : `CYC_2;
      end
      `OP_CMP:
      begin
        a_val    = trim({acc_high_half_out, acc_low_half_out}, width_in);
        b_val    = trim(operand_in, width_in);
        sum      = {1'b0, a_val} - {1'b0, b_val};
        nxt_flg  = arith_flags(a_val, b_val, sum, width_in, 1'b1);
      end
      `OP_WXCH:
      begin
        nxt_gw     = operand_in[15:0];
        nxt_gw_we  = 1'b1;
        nxt_res    = {16'h0000, general_word_reg_in};
        nxt_res_we = 1'b1;
        nxt_base   = `CYC_4;
      end
      `OP_WST_IND:
      begin
        nxt_res    = {16'h0000, acc_high_half_out};
        nxt_res_we = 1'b1;
        nxt_sa     = acc_low_half_out;
        nxt_flg    = {acc_high_half_out[15], acc_high_half_out == 16'h0000, flags_out[1:0]};
      end
      default:
      begin
        nxt_len  = `LEN_1;
        nxt_base = `CYC_1;
      end
    endcase
    // read-modify-write memory ops pay the access correction twice
    total = {2'b00, nxt_base};
    if (mem_op_in)
      total = total + {2'b00, addr_cost_in} + {2'b00, acc_corr_in}
              + (nxt_rmw ? {2'b00, acc_corr_in} : 6'h00);
  end

  // ==========================================================
  // sequencing and output registers
  // ==========================================================
  // results show at start; done pulses when the cycle budget is spent
  always @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      state_ff                <= ST_IDLE;
      cnt_ff                  <= 6'h00;
      busy_out                <= 1'b0;
      done_out                <= 1'b0;
      inst_len_out            <= 3'h0;
      cycles_out              <= 6'h00;
      acc_high_half_out       <= 16'h0000;
      acc_low_half_out        <= 16'h0000;
      flags_out               <= 4'h0;
      result_out              <= 32'h0000_0000;
      result_we_out           <= 1'b0;
      general_word_reg_out    <= 16'h0000;
      general_word_reg_we_out <= 1'b0;
      store_addr_out          <= 16'h0000;
    end
    else
    begin
      done_out                <= 1'b0;
      result_we_out           <= 1'b0;
      general_word_reg_we_out <= 1'b0;
      case (state_ff)
        ST_IDLE:
        begin
          if (start_in)
          begin
            acc_high_half_out       <= nxt_ah;
            acc_low_half_out        <= nxt_al;
            flags_out               <= nxt_flg;
            result_out              <= nxt_res;
            result_we_out           <= nxt_res_we;
            general_word_reg_out    <= nxt_gw;
            general_word_reg_we_out <= nxt_gw_we;
            store_addr_out          <= nxt_sa;
            inst_len_out            <= nxt_len;
            cycles_out              <= total;
            cnt_ff                  <= total - 6'h01;
            busy_out                <= 1'b1;
            state_ff                <= ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (cnt_ff <= 6'h01)
          begin
            done_out <= 1'b1;
            busy_out <= 1'b0;
            state_ff <= ST_IDLE;
          end
          else
            cnt_ff <= cnt_ff - 6'h01;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule // alu_move_dp

/* File: tb/alu_move_dp_asserts.sv */
// checker for the move / add / compare datapath, bound to its top module
// assumes: datapath header on the include path; one clock, sync reset
`timescale 1ns/100ps
`include "alu_move_map.vh"
// ==========
// checker
module alu_move_chk
(
  // clock, reset and request
  input wire        clk_in,
  input wire        sys_rst_in,
  input wire        start_in,
  input wire [4:0]  op_in,
  input wire [31:0] imm_in,
  // results
  input wire        busy_out,
  input wire        done_out,
  input wire [2:0]  inst_len_out,
  input wire [5:0]  cycles_out,
  input wire [15:0] acc_high_half_out,
  input wire [15:0] acc_low_half_out,
  input wire [3:0]  flags_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  // a start is only taken while idle, so one seen while busy is no take
  wire       take = start_in & ~busy_out;
  reg  [5:0] age_ff;
  wire [5:0] nxt_age = take ? 6'h01 : age_ff + 6'h01;
  // cycles since the take, compared with the reported budget at done
  always @(posedge clk_in)
    age_ff <= sys_rst_in ? 6'h00 : nxt_age;
  take_busy_a: assert property (take |=> busy_out)
    else $error("busy not raised after start");
  done_age_a: assert property (done_out |-> age_ff == cycles_out)
    else $error("done off its cycle budget");
  fall_done_a: assert property (!$past(sys_rst_in) && $fell(busy_out) |-> done_out)
    else $error("busy dropped without done");
  push_half_a: assert property (take && op_in == `OP_WMOV_IMM |=>
    acc_high_half_out == $past(acc_low_half_out) && acc_low_half_out == 16'($past(imm_in)))
    else $error("word load or push wrong");
  long_load_a: assert property (take && op_in == `OP_LMOV_IMM |=>
    {acc_high_half_out, acc_low_half_out} == $past(imm_in))
    else $error("long load wrong");
  quiet_flags_a: assert property (take && (op_in == `OP_WMOV_IO ||
    op_in == `OP_WXCH) |=> $stable(flags_out))
    else $error("flags moved");
  dec_clear_a: assert property (take && (op_in == `OP_BADDC_DEC ||
    op_in == `OP_BSUBC_DEC) |=> acc_low_half_out[15:8] == 8'h00)
    else $error("bits 15 to 8 not cleared");
  carry_keep_a: assert property (take && (op_in == `OP_INC ||
    op_in == `OP_DEC) |=> $stable(flags_out[0]))
    else $error("carry changed by inc or dec");
  cmp_keep_a: assert property (take && op_in == `OP_CMP |=>
    $stable(acc_low_half_out) && $stable(acc_high_half_out))
    else $error("compare stored a result");
  wadd_cost_a: assert property (take && op_in == `OP_WADD_ACC |=>
    inst_len_out == 3'h1 && cycles_out == 6'h02)
    else $error("word add length or cycles wrong");
  xchg_c: cover property (take && op_in == `OP_WXCH);
  refuse_c: cover property (start_in && busy_out);
  long_c: cover property (done_out && cycles_out == 6'h09);
endmodule // alu_move_chk
bind alu_move_dp alu_move_chk u_chk
(
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in), .op_in(op_in),
  .imm_in(imm_in), .busy_out(busy_out), .done_out(done_out),
  .inst_len_out(inst_len_out), .cycles_out(cycles_out), .flags_out(flags_out),
  .acc_high_half_out(acc_high_half_out), .acc_low_half_out(acc_low_half_out)
);

/* File: tb/seq_mem_model.sv */
// operand store standing in for sequencer and memory unit
// assumes: bench loads operand and register before each operation
`timescale 1ns/100ps
// ==========
// partner
module seq_mem_model
(
  // clock and bench load
  input  wire        clk_in,
  input  wire        ld_in,
  input  wire [31:0] ld_opnd_in,
  input  wire [15:0] ld_reg_in,
  // write-backs from the datapath
  input  wire [31:0] result_in,
  input  wire        result_we_in,
  input  wire [15:0] reg_wr_in,
  input  wire        reg_we_in,
  // operand values to the datapath
  output reg  [31:0] opnd_out = 32'h0000_0000,
  output reg  [15:0] reg_out = 16'h0000
);
  // write-backs land on the edge of their pulse, so the swap is visible at done
  always @(posedge clk_in)
  begin
    if (ld_in)
    begin
      opnd_out <= ld_opnd_in;
      reg_out <= ld_reg_in;
    end
    else
    begin
      if (result_we_in)
        opnd_out <= result_in;
      if (reg_we_in)
        reg_out <= reg_wr_in;
    end
  end
endmodule // seq_mem_model

/* File: tb/testbench.sv */
// self-checking bench for the move / add / compare datapath
// assumes: datapath header on the include path, partner in seq_mem_model
`timescale 1ns/100ps
`include "alu_move_map.vh"
module testbench;
  // ==========
  // stimulus and observation
  reg         clk_in = 1'b0;
  reg         sys_rst_in = 1'b1;
  reg         start_in = 1'b0;
  reg  [4:0]  op_in = 5'h00;
  reg  [1:0]  width_in = 2'h0;
  reg         mem_op_in = 1'b0;
  reg  [3:0]  addr_cost_in = 4'h0;
  reg  [3:0]  acc_corr_in = 4'h0;
  reg  [31:0] imm_in = 32'h0000_0000;
  reg         ld = 1'b0;
  reg  [31:0] ld_opnd = 32'h0000_0000;
  wire [31:0] operand_in, result_out;
  wire [15:0] gwr_in, gwr_out, hi, lo, store_addr_out;
  wire [5:0]  cycles_out;
  wire [3:0]  flags_out;
  wire [2:0]  inst_len_out;
  wire        busy_out, done_out, result_we_out, gwr_we;
  integer     failures = 0;
  integer     num_checks = 0;
  alu_move_dp i_dut
  (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .start_in(start_in), .op_in(op_in),
    .width_in(width_in), .mem_op_in(mem_op_in), .addr_cost_in(addr_cost_in),
    .acc_corr_in(acc_corr_in), .imm_in(imm_in), .operand_in(operand_in),
    .general_word_reg_in(gwr_in), .busy_out(busy_out), .done_out(done_out),
    .inst_len_out(inst_len_out), .cycles_out(cycles_out), .acc_high_half_out(hi),
    .acc_low_half_out(lo), .flags_out(flags_out), .result_out(result_out),
    .result_we_out(result_we_out), .general_word_reg_out(gwr_out),
    .general_word_reg_we_out(gwr_we), .store_addr_out(store_addr_out)
  );
  seq_mem_model i_mem
  (
    .clk_in(clk_in), .ld_in(ld), .ld_opnd_in(ld_opnd), .ld_reg_in(16'hAAAA),
    .result_in(result_out), .result_we_in(result_we_out), .reg_wr_in(gwr_out),
    .reg_we_in(gwr_we), .opnd_out(operand_in), .reg_out(gwr_in)
  );
  always #2.5 clk_in = ~clk_in;
  // ==========
  // compare and access tasks
  task chk(input [31:0] g, input [31:0] e);
    begin
      num_checks = num_checks + 1;
      if (g !== e)
      begin
        failures = failures + 1;
        $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  // flags compared under a mask where a flag's value is left open
  task chkf(input [3:0] e, input [3:0] m);
    chk(32'(flags_out & m), 32'(e));
  endtask
  // load the partner, pulse start, count cycles to done; rf pokes a start while busy
  task run(input [4:0] o, input [31:0] i, input [31:0] d, input [2:0] l, input [5:0] y,
           input [1:0] w = 2'h0, input [3:0] a = 4'h0, input [3:0] c = 4'h0,
           input rf = 1'b0);
    integer n;
    begin
      op_in = o;
      width_in = w;
      mem_op_in = |{a, c};
      addr_cost_in = a;
      acc_corr_in = c;
      imm_in = i;
      ld_opnd = d;
      ld = 1'b1;
      @(negedge clk_in);
      ld = 1'b0;
      start_in = 1'b1;
      n = 0;
      while (done_out !== 1'b1 && n < 40)
      begin
        @(negedge clk_in);
        n = n + 1;
        start_in = rf && n == 1;
        op_in = (rf && n == 1) ? `OP_WMOV_IMM : o;
      end
      chk(32'(n), 32'(y));
      chk(32'(cycles_out), 32'(y));
      if (l != 3'h0)
        chk(32'(inst_len_out), 32'(l));
      $display("test op %h took %0d cycles", o, n);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // ==========
  // watchdog, far beyond the hundred or so cycles the tests need
  initial
  begin
    #20000;
    failures = failures + 1;
    $display("ERROR %0t: watchdog expired", $time);
    give_verdict;
  end
  // ==========
  // test sequence
  initial
  begin
    repeat (8) @(negedge clk_in);
    sys_rst_in = 1'b0;
    chk({hi, lo}, 32'h0000_0000);
    chkf(4'h0, 4'hF);
    run(`OP_WMOV_IMM, 32'h0000_8000, 32'h0, 3'h3, 6'h02);
    chk({hi, lo}, 32'h0000_8000);
    chkf(4'h8, 4'hF);
    run(`OP_WMOV_IMM, 32'h0000_0001, 32'h0, 3'h3, 6'h02);
    chk({hi, lo}, 32'h8000_0001);
    run(`OP_WADD_ACC, 32'h0, 32'h0, 3'h1, 6'h02);
    chk({hi, lo}, 32'h8000_8001);
    chkf(4'h8, 4'hF);
    run(`OP_WADDC_REG, 32'h0, 32'h0000_7FFF, 3'h2, 6'h02);
    chkf(4'h5, 4'hF);
    run(`OP_WADDC_REG, 32'h0, 32'h0000_0001, 3'h2, 6'h02);
    chk({hi, lo}, 32'h8000_0002);
    run(`OP_WST_IND, 32'h0, 32'h0, 3'h2, 6'h02);
    chk({result_out[15:0], store_addr_out}, 32'h8000_0002);
    chkf(4'h8, 4'hF);
    run(`OP_WMOV_IO, 32'h0000_1234, 32'h0, 3'h4, 6'h04, 2'h0, 4'h0, 4'h1);
    chk(32'(result_out[15:0]), 32'h0000_1234);
    run(`OP_CMP, 32'h0, 32'h0000_0003, 3'h0, 6'h02, 2'h1);
    chkf(4'h9, 4'hF);
    run(`OP_WXCH, 32'h0, 32'h0000_5555, 3'h2, 6'h04);
    chk({operand_in[15:0], gwr_in}, 32'hAAAA_5555);
    chkf(4'h9, 4'hF);
    run(`OP_INC, 32'h0, 32'hFFFF_FFFF, 3'h2, 6'h04, 2'h2);
    chk(result_out, 32'h0000_0000);
    chkf(4'h5, 4'hF);
    run(`OP_INC, 32'h0, 32'h0000_007F, 3'h0, 6'h06, 2'h0, 4'h1, 4'h1);
    chk(32'(result_out[7:0]), 32'h0000_0080);
    chkf(4'hB, 4'hF);
    run(`OP_LMOV_IMM, 32'h1234_5678, 32'h0, 3'h5, 6'h03);
    chk({hi, lo}, 32'h1234_5678);
    chkf(4'h3, 4'hF);
    run(`OP_LADD_IMM, 32'hEDCB_A988, 32'h0, 3'h5, 6'h04);
    chkf(4'h5, 4'hF);
    run(`OP_LADD_REG, 32'h0, 32'h0000_0001, 3'h2, 6'h05, 2'h2, 4'h0, 4'h0, 1'b1);
    chk({hi, lo}, 32'h0000_0001);
    run(`OP_WMOV_IMM, 32'h0000_0058, 32'h0, 3'h3, 6'h02);
    run(`OP_WMOV_IMM, 32'h0000_1247, 32'h0, 3'h3, 6'h02);
    run(`OP_BADDC_DEC, 32'h0, 32'h0, 3'h1, 6'h03);
    chk({hi, lo}, 32'h0058_0005);
    chkf(4'h1, 4'hD);
    run(`OP_BSUBC_DEC, 32'h0, 32'h0, 3'h1, 6'h03);
    chk({hi, lo}, 32'h0058_0052);
    chkf(4'h0, 4'hD);
    run(`OP_BADD_MEM, 32'h0, 32'h0000_0030, 3'h0, 6'h07, 2'h0, 4'h2, 4'h1);
    chk(32'(result_out[7:0]), 32'h0000_0082);
    chkf(4'hA, 4'hF);
    run(`OP_BSUB_MEM, 32'h0, 32'h0000_0030, 3'h0, 6'h09, 2'h0, 4'h0, 4'h3);
    chk(32'(result_out[7:0]), 32'h0000_00DE);
    chkf(4'h9, 4'hF);
    give_verdict;
  end
endmodule // testbench
